/* src/i2sp_port.sv */
// Functional notes
// - Burst sends address and subaddress only once
// - Advance subaddress each word until stop
// - Control words two bytes, memory words four
// - Subaddress grows by one per word always
// - Address bits 0 and 1 from strap pins
// - Respond to 0x38 through 0x3B
// - Device is only ever a target
// - Address byte LSB one reads, zero writes
// - Start is data falling with clock high
// - Shift eight bits, acknowledge on ninth
// - Address mismatch releases bus, goes idle
// - Transfer lasts until stop condition
// - Stray start or stop abandons to idle
// - Invalid subaddress gets no acknowledge, idle
// - Open-drain two-wire, push-pull four-wire data
// - Two subaddress bytes, MSB first, then data
// - Three select lows switch to four-wire
// - Before lock only synthesiser registers reachable; code checks the written subaddress only, not reads or burst increments
`timescale 1ns/1ps
`include "i2sp_cfg.svh"
module i2sp_port (
    // System clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Link pins
    input wire logic control_port_clock_pin_in,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe_out,
    input wire logic select_or_strap_bit_a_pin_in,
    input wire logic serial_in_or_strap_bit_b_pin_in,
    // Four-wire engine hookup
    input wire logic spi_data_in,
    input wire logic spi_data_oe_in,
    output logic four_wire_mode_out,
    // Status from the clock synthesiser
    input wire logic pll_locked_in,
    // Register and memory access
    output logic [15:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    output logic mem_wr_out,
    output logic mem_rd_out,
    input wire logic [31:0] mem_rdata_in
);
    logic [4:0] pins_s;
    logic scl_s, sda_s, sel_s, sin_s, tog_s, link_bit;
    logic link_tog, scl_q, sda_q, tog_q;
    logic start_ev, stop_ev, rise_ev, fall_ev, byte_done, addr_match, sub_ok, last_byte;
    logic [7:0] byte_w;
    logic [15:0] sub_w;
    logic [2:0] wlen;
    i2sp_pkg::i2sp_state_type state_q;
    logic [3:0] cnt_q;
    logic in_ack_q, ack_q, tx_byte_q, nack_q;
    logic [7:0] shift_q, tx_q;
    logic [31:0] rd_word_q;
    logic [2:0] byte_idx_q;
    logic [1:0] strap_cnt_q;
    logic strap_a_q, strap_b_q;
    logic [3:0] low_cnt_q;
    logic [1:0] toggles_q;
    logic spi_mode_q, oe_q, pin_out_q, pin_oe_q;

    i2sp_link u_link (
        .link_clk_in(control_port_clock_pin_in),
        .rst_in(sys_rst_in),
        .sda_in(serial_data_pin_in),
        .bit_out(link_bit),
        .toggle_out(link_tog)
    );

    i2sp_sync #(.W(5), .RST(`I2SP_PIN_RST)) u_sync (
        .clk_in(clk_in),
        .rst_in(sys_rst_in),
        .d_in({link_tog, serial_in_or_strap_bit_b_pin_in, select_or_strap_bit_a_pin_in,
               serial_data_pin_in, control_port_clock_pin_in}),
        .q_out(pins_s)
    );

    assign {tog_s, sin_s, sel_s, sda_s, scl_s} = pins_s;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            tog_q <= 1'b0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            tog_q <= tog_s;
        end
    end

    assign start_ev = ~spi_mode_q & scl_s & scl_q & sda_q & ~sda_s;
    assign stop_ev = ~spi_mode_q & scl_s & scl_q & ~sda_q & sda_s;
    assign rise_ev = ~spi_mode_q & (tog_s ^ tog_q) & (state_q != i2sp_pkg::st_idle);
    assign fall_ev = ~spi_mode_q & scl_q & ~scl_s & (state_q != i2sp_pkg::st_idle);
    assign byte_done = rise_ev & ~in_ack_q & (cnt_q == 4'h7);
    assign byte_w = {shift_q[6:0], link_bit};
    assign addr_match = byte_w[7:1] == {`I2SP_ADDR_FIXED, strap_b_q, strap_a_q};
    assign sub_w = {mem_addr_out[15:8], byte_w};
    assign sub_ok = pll_locked_in ? (sub_w < `I2SP_MEM_LIMIT || sub_w >= `I2SP_CTRL_BASE)
                                  : (sub_w >= `I2SP_PLL_FIRST && sub_w <= `I2SP_PLL_LAST);
    assign wlen = (mem_addr_out >= `I2SP_CTRL_BASE) ? `I2SP_CTRL_BYTES : `I2SP_MEM_BYTES;
    assign last_byte = byte_idx_q == wlen - 3'h1;

    // Straps are caught once, after the synchroniser has filled
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            strap_cnt_q <= 2'h0;
            strap_a_q <= 1'b0;
            strap_b_q <= 1'b0;
        end else if (strap_cnt_q != `I2SP_STRAP_WAIT) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == `I2SP_STRAP_WAIT - 2'h1) begin
                strap_a_q <= sel_s;
                strap_b_q <= sin_s;
            end
        end
    end

    // Four-wire mode is sticky until reset
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            low_cnt_q <= 4'h0;
            toggles_q <= 2'h0;
            spi_mode_q <= 1'b0;
        end else if (!sel_s) begin
            if (low_cnt_q != 4'hf) begin
                low_cnt_q <= low_cnt_q + 4'h1;
            end
        end else begin
            low_cnt_q <= 4'h0;
            if (low_cnt_q >= 4'(`I2SP_SEL_LOW_CYC) && !spi_mode_q) begin
                toggles_q <= toggles_q + 2'h1;
                if (toggles_q == `I2SP_SEL_TOGGLES - 2'h1) begin
                    spi_mode_q <= 1'b1;
                end
            end
        end
    end

    // Byte framing and protocol state
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= i2sp_pkg::st_idle;
            cnt_q <= 4'h0;
            in_ack_q <= 1'b0;
            ack_q <= 1'b0;
            tx_byte_q <= 1'b0;
            nack_q <= 1'b0;
            shift_q <= 8'h00;
        end else if (spi_mode_q || stop_ev) begin
            state_q <= i2sp_pkg::st_idle;
            cnt_q <= 4'h0;
            in_ack_q <= 1'b0;
        end else if (start_ev) begin
            // The start's own clock rise counted one bit, so a count of one means between bytes
            if (state_q == i2sp_pkg::st_idle || (cnt_q == 4'h1 && !in_ack_q)) begin
                state_q <= i2sp_pkg::st_addr;
            end else begin
                state_q <= i2sp_pkg::st_idle;
            end
            cnt_q <= 4'h0;
            in_ack_q <= 1'b0;
        end else if (rise_ev && in_ack_q) begin
            nack_q <= link_bit;
        end else if (rise_ev) begin
            shift_q <= byte_w;
            cnt_q <= cnt_q + 4'h1;
            if (byte_done) begin
                tx_byte_q <= state_q == i2sp_pkg::st_rd;
                ack_q <= 1'b1;
                case (state_q)
                    i2sp_pkg::st_addr: begin
                        ack_q <= addr_match;
                        if (!addr_match) begin
                            state_q <= i2sp_pkg::st_idle;
                        end else if (byte_w[0]) begin
                            state_q <= i2sp_pkg::st_rd;
                        end else begin
                            state_q <= i2sp_pkg::st_sub_hi;
                        end
                    end
                    i2sp_pkg::st_sub_hi: state_q <= i2sp_pkg::st_sub_lo;
                    i2sp_pkg::st_sub_lo: begin
                        ack_q <= sub_ok;
                        state_q <= sub_ok ? i2sp_pkg::st_wr : i2sp_pkg::st_idle;
                    end
                    i2sp_pkg::st_rd: ack_q <= 1'b0;
                    default: state_q <= state_q;
                endcase
            end
        end else if (fall_ev && in_ack_q) begin
            in_ack_q <= 1'b0;
            cnt_q <= 4'h0;
            if (tx_byte_q && nack_q) begin
                state_q <= i2sp_pkg::st_idle;
            end
        end else if (fall_ev && cnt_q == 4'h8) begin
            in_ack_q <= 1'b1;
            nack_q <= 1'b0;
        end
    end

    // Subaddress, word assembly and access strobes
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem_addr_out <= 16'h0000;
            mem_wdata_out <= 32'h00000000;
            mem_wr_out <= 1'b0;
            byte_idx_q <= 3'h0;
        end else begin
            mem_wr_out <= 1'b0;
            // Bump after the write strobe so the strobe sees the word's own address
            if (mem_wr_out) begin
                mem_addr_out <= mem_addr_out + 16'h0001;
            end
            if (start_ev || stop_ev) begin
                byte_idx_q <= 3'h0;
            end else if (byte_done) begin
                case (state_q)
                    i2sp_pkg::st_sub_hi: mem_addr_out[15:8] <= byte_w;
                    i2sp_pkg::st_sub_lo: begin
                        mem_addr_out[7:0] <= byte_w;
                        byte_idx_q <= 3'h0;
                    end
                    i2sp_pkg::st_wr: begin
                        mem_wdata_out <= (byte_idx_q == 3'h0) ? {24'h000000, byte_w}
                                                                : {mem_wdata_out[23:0], byte_w};
                        mem_wr_out <= last_byte;
                        byte_idx_q <= last_byte ? 3'h0 : byte_idx_q + 3'h1;
                    end
                    i2sp_pkg::st_rd: begin
                        if (last_byte) begin
                            mem_addr_out <= mem_addr_out + 16'h0001;
                        end
                        byte_idx_q <= last_byte ? 3'h0 : byte_idx_q + 3'h1;
                    end
                    default: byte_idx_q <= byte_idx_q;
                endcase
            end
        end
    end

    // Data line drive; only ever pulls low, never starts traffic
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            oe_q <= 1'b0;
            tx_q <= 8'h00;
            rd_word_q <= 32'h00000000;
            mem_rd_out <= 1'b0;
        end else begin
            mem_rd_out <= 1'b0;
            if (spi_mode_q || start_ev || stop_ev || state_q == i2sp_pkg::st_idle) begin
                oe_q <= 1'b0;
            end else if (rise_ev && !in_ack_q && state_q == i2sp_pkg::st_rd) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end else if (fall_ev && cnt_q == 4'h8 && !in_ack_q) begin
                oe_q <= ack_q;
            end else if (fall_ev && in_ack_q) begin
                oe_q <= 1'b0;
                if (state_q == i2sp_pkg::st_rd && !(tx_byte_q && nack_q)) begin
                    if (byte_idx_q == 3'h0) begin
                        mem_rd_out <= 1'b1;
                        tx_q <= (wlen == `I2SP_MEM_BYTES) ? mem_rdata_in[31:24] : mem_rdata_in[15:8];
                        oe_q <= ~((wlen == `I2SP_MEM_BYTES) ? mem_rdata_in[31] : mem_rdata_in[15]);
                        rd_word_q <= (wlen == `I2SP_MEM_BYTES) ? {mem_rdata_in[23:0], 8'h00}
                                                                : {mem_rdata_in[7:0], 24'h000000};
                    end else begin
                        tx_q <= rd_word_q[31:24];
                        oe_q <= ~rd_word_q[31];
                        rd_word_q <= {rd_word_q[23:0], 8'h00};
                    end
                end
            end else if (fall_ev && state_q == i2sp_pkg::st_rd && cnt_q != 4'h0) begin
                oe_q <= ~tx_q[7];
            end
        end
    end

    // Shared pin: open drain in two-wire mode, push-pull in four-wire mode
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_out_q <= spi_mode_q ? spi_data_in : 1'b0;
            pin_oe_q <= spi_mode_q ? spi_data_oe_in : oe_q;
        end
    end

    assign serial_data_pin_out = pin_out_q;
    assign serial_data_pin_oe_out = pin_oe_q;
    assign four_wire_mode_out = spi_mode_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_start_to_addr: assert property (
        start_ev && state_q == i2sp_pkg::st_idle |=> state_q == i2sp_pkg::st_addr)
        else $error("start not taken from idle");
    a_stop_to_idle: assert property (
        stop_ev |=> state_q == i2sp_pkg::st_idle ##1 !serial_data_pin_oe_out)
        else $error("stop did not end transfer");
    a_mismatch_idle: assert property (
        byte_done && state_q == i2sp_pkg::st_addr && !addr_match |=> state_q == i2sp_pkg::st_idle && !ack_q)
        else $error("mismatched address not released");
    a_dir_read: assert property (
        byte_done && state_q == i2sp_pkg::st_addr && addr_match && byte_w[0] |=> state_q == i2sp_pkg::st_rd)
        else $error("read direction not taken");
    a_bad_sub_nack: assert property (
        byte_done && state_q == i2sp_pkg::st_sub_lo && !sub_ok |=> !ack_q && state_q == i2sp_pkg::st_idle)
        else $error("invalid subaddress acknowledged");
    a_ack_drive: assert property (
        fall_ev && cnt_q == 4'h8 && !in_ack_q && ack_q && !start_ev && !stop_ev |=> ##1 serial_data_pin_oe_out)
        else $error("acknowledge not driven");
    a_sub_incr: assert property (
        mem_wr_out |=> mem_addr_out == $past(mem_addr_out) + 16'h0001)
        else $error("subaddress not advanced after word");
    a_idle_release: assert property (
        state_q == i2sp_pkg::st_idle && !spi_mode_q ##1 !spi_mode_q |=> !serial_data_pin_oe_out)
        else $error("bus driven while idle");
    a_four_wire_pin: assert property (
        spi_mode_q && $past(spi_mode_q) |=> serial_data_pin_oe_out == $past(spi_data_oe_in))
        else $error("four-wire pin not push-pull");
    a_word_len: assert property (
        byte_done && state_q == i2sp_pkg::st_wr && mem_addr_out >= `I2SP_CTRL_BASE && byte_idx_q == 3'h1
        |=> mem_wr_out)
        else $error("control word not two bytes");
endmodule

/* inc/i2sp_cfg.svh */
`ifndef I2SP_CFG_SVH
`define I2SP_CFG_SVH
`define I2SP_ADDR_FIXED 5'h0e
`define I2SP_CTRL_BASE 16'hf000
`define I2SP_MEM_LIMIT 16'ha000
`define I2SP_PLL_FIRST 16'hf000
`define I2SP_PLL_LAST 16'hf004
`define I2SP_CTRL_BYTES 3'h2
`define I2SP_MEM_BYTES 3'h4
`define I2SP_SEL_TOGGLES 2'h3
`define I2SP_CLK_MHZ 125
`define I2SP_SEL_LOW_MIN_NS 8
`define I2SP_SEL_LOW_CYC ((`I2SP_SEL_LOW_MIN_NS * `I2SP_CLK_MHZ + 999) / 1000)
`define I2SP_STRAP_WAIT 2'h3
`define I2SP_PIN_RST 5'h0f
`endif

/* inc/i2sp_pkg.sv */
package i2sp_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_addr = 3'h1,
        st_sub_hi = 3'h2,
        st_sub_lo = 3'h3,
        st_wr = 3'h4,
        st_rd = 3'h5
    } i2sp_state_type;
endpackage

/* src/i2sp_sync.sv */
`timescale 1ns/1ps
module i2sp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Levels
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= RST;
            q_out <= RST;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule

/* src/i2sp_link.sv */
`timescale 1ns/1ps
module i2sp_link (
    // Link clock and reset
    input wire logic link_clk_in,
    input wire logic rst_in,
    // Data line
    input wire logic sda_in,
    output logic bit_out,
    output logic toggle_out
);
    // Bit is held a whole clock period, so the toggle alone needs syncing
    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_out <= 1'b1;
            toggle_out <= 1'b0;
        end else begin
            bit_out <= sda_in;
            toggle_out <= ~toggle_out;
        end
    end
endmodule

/* verification/i2sp_master_model.sv */
`timescale 1ns/1ps
module i2sp_master_model (
    // Bus lines
    output logic scl_out,
    output logic sda_drv_out,
    input wire logic sda_in
);
    logic tck;

    // 80 ns tick, offset so it never lines up with the system clock
    initial begin
        tck = 1'b0;
        #3;
        forever #40 tck = ~tck;
    end

    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge tck);
    endtask

    // Quarter of 8 ticks keeps one bit at 2.56 us
    task automatic clk_bit(input logic b, output logic s);
        wt(8);
        sda_drv_out = b;
        wt(8);
        scl_out = 1'b1;
        wt(8);
        s = sda_in;
        wt(8);
        scl_out = 1'b0;
    endtask

    // One start per high phase, also used as repeated start
    task automatic start();
        wt(8);
        sda_drv_out = 1'b1;
        wt(8);
        scl_out = 1'b1;
        wt(8);
        sda_drv_out = 1'b0;
        wt(8);
        scl_out = 1'b0;
    endtask

    // Clock left standing high between frames
    task automatic stop();
        wt(8);
        sda_drv_out = 1'b0;
        wt(8);
        scl_out = 1'b1;
        wt(8);
        sda_drv_out = 1'b1;
        wt(8);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask

    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(nack, s);
    endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_in, sys_rst_in, pll_locked_in, strap_a, strap_b, spi_data_in, spi_data_oe_in;
    logic scl, m_sda, sda_w, dout, doe, fw, mwr, mrs;
    logic [15:0] maddr;
    logic [31:0] mwd, mrd, d, r;
    logic [7:0] b0, b1, b2, b3;
    logic [6:0] a7;
    logic [15:0] sa;
    logic s;
    logic [47:0] wq[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int n_rd = 0;
    int seed = 32'h0333;

    i2sp_port dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .control_port_clock_pin_in(scl),
        .serial_data_pin_in(sda_w), .serial_data_pin_out(dout), .serial_data_pin_oe_out(doe),
        .select_or_strap_bit_a_pin_in(strap_a), .serial_in_or_strap_bit_b_pin_in(strap_b),
        .spi_data_in(spi_data_in), .spi_data_oe_in(spi_data_oe_in), .four_wire_mode_out(fw),
        .pll_locked_in(pll_locked_in), .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_wr_out(mwr),
        .mem_rd_out(mrs), .mem_rdata_in(mrd));
    i2sp_master_model m_u (.scl_out(scl), .sda_drv_out(m_sda), .sda_in(sda_w));

    // Pulled-up wire: low if either party pulls it down
    assign sda_w = (doe ? dout : 1'b1) & m_sda;
    assign mrd = {~maddr, maddr ^ 16'ha5c3};

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (mwr === 1'b1) begin
            wq.push_back({maddr, mwd});
        end
        if (mrs === 1'b1) begin
            n_rd++;
        end
    end

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] st);
        @(negedge clk_in);
        sys_rst_in = 1'b1;
        {strap_b, strap_a} = st;
        repeat (6) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (8) @(negedge clk_in);
    endtask

    task automatic wb(input logic [7:0] v, input logic e);
        logic ack;
        m_u.wr_byte(v, ack);
        chk_bit("ack", e, ack);
    endtask

    // Expected write entry: pop and compare, or flag a missing one
    task automatic chk_wr(input string nm, input logic [47:0] e);
        if (wq.size() > 0) begin
            chk_word(nm, e, wq.pop_front());
        end else begin
            chk_word(nm, e, 48'h0);
        end
    endtask

    initial begin
        // Whole scenario list needs about 0.93 ms of bus time
        #1_000_000;
        n_mismatch++;
        test_done();
    end

    initial begin
        sys_rst_in = 1'b1;
        pll_locked_in = 1'b1;
        strap_a = 1'b0;
        strap_b = 1'b0;
        spi_data_in = 1'b0;
        spi_data_oe_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            do_reset(i[1:0]);
            m_u.start();
            wb({5'h0e, i[1:0], 1'b0}, 1'b1);
            m_u.stop();
            chk_bit("oe_idle", 1'b0, doe);
        end
        r = $random(seed);
        a7 = {5'h0e, r[1:0]};
        do_reset(r[1:0]);
        m_u.start();
        wb({5'h0e, r[1:0] + 2'h1, 1'b0}, 1'b0);
        m_u.start();
        wb({a7, 1'b0}, 1'b1);
        m_u.stop();
        // Burst of two control words from 0xf001
        d = $random(seed);
        wq.delete();
        m_u.start();
        wb({a7, 1'b0}, 1'b1);
        wb(8'hf0, 1'b1);
        wb(8'h01, 1'b1);
        for (int i = 3; i >= 0; i--) begin
            wb(d[i*8 +: 8], 1'b1);
        end
        m_u.stop();
        chk_wr("wr0", {16'hf001, 16'h0, d[31:16]});
        chk_wr("wr1", {16'hf002, 16'h0, d[15:0]});
        // One memory word, then a partial word cut by stop
        sa = 16'($random(seed)) & 16'h7ffe;
        d = $random(seed);
        m_u.start();
        wb({a7, 1'b0}, 1'b1);
        wb(sa[15:8], 1'b1);
        wb(sa[7:0], 1'b1);
        for (int i = 3; i >= 0; i--) begin
            wb(d[i*8 +: 8], 1'b1);
        end
        wb(8'h5a, 1'b1);
        m_u.stop();
        chk_wr("wr_mem", {sa, d});
        chk_word("wr_left", 48'h0, 48'(wq.size()));
        chk_word("addr_next", {32'h0, sa + 16'h1}, {32'h0, maddr});
        // Read two control words through a repeated start
        m_u.start();
        wb({a7, 1'b0}, 1'b1);
        wb(8'hf0, 1'b1);
        wb(8'h03, 1'b1);
        m_u.start();
        wb({a7, 1'b1}, 1'b1);
        m_u.rd_byte(1'b0, b0);
        m_u.rd_byte(1'b0, b1);
        m_u.rd_byte(1'b0, b2);
        m_u.rd_byte(1'b1, b3);
        m_u.stop();
        chk_word("rd", {16'h0, 16'hf003 ^ 16'ha5c3, 16'hf004 ^ 16'ha5c3}, {16'h0, b0, b1, b2, b3});
        chk_bit("oe_rel", 1'b0, doe);
        chk_word("rd_fetch", 48'h2, 48'(n_rd));
        chk_word("rd_addr", {32'h0, 16'hf005}, {32'h0, maddr});
        // Before lock only the synthesiser window answers
        @(negedge clk_in);
        pll_locked_in = 1'b0;
        m_u.start();
        wb({a7, 1'b0}, 1'b1);
        wb(8'hf0, 1'b1);
        wb(8'h05, 1'b0);
        m_u.start();
        wb({a7, 1'b0}, 1'b1);
        wb(8'hf0, 1'b1);
        wb(8'h04, 1'b1);
        m_u.stop();
        @(negedge clk_in);
        pll_locked_in = 1'b1;
        // Start in mid-byte abandons without opening a new address
        m_u.start();
        wb({a7, 1'b0}, 1'b1);
        for (int i = 0; i < 4; i++) begin
            m_u.clk_bit(1'b1, s);
        end
        m_u.start();
        wb({a7, 1'b0}, 1'b0);
        m_u.stop();
        // Three select lows switch to four-wire
        for (int i = 0; i < 3; i++) begin
            chk_bit("mode", 1'b0, fw);
            @(negedge clk_in);
            strap_a = 1'b0;
            repeat (3) @(negedge clk_in);
            strap_a = 1'b1;
            repeat (8) @(negedge clk_in);
        end
        chk_bit("mode", 1'b1, fw);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            spi_data_in = r[0];
            spi_data_oe_in = r[1];
            repeat (3) @(negedge clk_in);
            chk_bit("pp_data", r[0], dout);
            chk_bit("pp_oe", r[1], doe);
        end
        test_done();
    end
endmodule
